// [rtl/huq_pkg.sv]
package huq_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int FRM_W = 12;
  // register offsets
  localparam logic [2:0] OFS_TXBUF = 3'h0;
  localparam logic [2:0] OFS_RXBUF = 3'h1;
  localparam logic [2:0] OFS_MODE0 = 3'h2;
  localparam logic [2:0] OFS_MODE1 = 3'h3;
  localparam logic [2:0] OFS_MODE2 = 3'h4;
  localparam logic [2:0] OFS_STAT = 3'h5;
  // mode 1 fields
  localparam int M1_CMD = 0;
  localparam int M1_CKM = 3;
  localparam int M1_SBOS = 4;
  localparam int M1_SBIS = 5;
  localparam int M1_IOM = 7;
  // mode 2 fields
  localparam int M2_BRKE = 0;
  localparam int M2_NPE = 1;
  localparam int M2_PM = 2;
  localparam int M2_FM = 4;
  localparam int M2_BRKF = 7;
  // mode 0 fields
  localparam int M0_DIR = 4;
  // status fields
  localparam int ST_ORE = 0;
  localparam int ST_PEK = 1;
  localparam int ST_FEF = 2;
  localparam int ST_ERE = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_TFULL = 5;
  localparam int ST_RFULL = 6;
  // reset value and mode 2 write mask
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODE2_WMASK = 8'h3f;
  // bit timing in source ticks
  localparam logic [3:0] TICK_LAST = 4'h7;
  localparam logic [3:0] TICK_HALF = 4'h4;
  // frame pieces
  localparam logic [3:0] LEN_D7 = 4'h7;
  localparam logic [3:0] LEN_D8 = 4'h8;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [1:0] PM_ZERO = 2'h0;
  localparam logic [1:0] PM_ONE = 2'h1;
  localparam logic [1:0] PM_ODD = 2'h2;
  typedef enum {S_IDLE, S_TX, S_RX} huq_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } huq_req_t;
endpackage

// [rtl/huq_uart.sv]
// Behaviour
// - writing the transmit buffer alone starts a frame with a start bit
// - start accepted only after input low longer than half a bit
// - half duplex: no reception while sending, no sending while receiving
// - a detected start clears the bit counter and begins a new frame
// - frame mode field picks 7 or 8 data bits and 1 or 2 stops
// - in asynchronous mode the synchronous bit count field is ignored
// - input pin select takes data from receive pin or transmit pin
// - frame is start bit, character bits, optional parity, stop bits
// - parity off, or forced 0, forced 1, odd or even
// - break enable sends zero on every frame bit
// - overrun, parity and framing flags plus a summary error flag
// - parity and framing flags updated at each receive completion pulse
// - overrun set on unread buffer; cleared at completion after a read
// - parity error on a mismatching received parity bit
// - framing error when a stop bit is not high
// - error flags never alter how transfers proceed
// - clearing both pin enables resets the function and the overrun
// - break flag set at completion when every frame bit was zero
// - a buffered byte follows the current frame without a gap
`timescale 1ns/10ps
`default_nettype none
module huq_uart (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire huq_pkg::huq_req_t bus_req,
  output logic [huq_pkg::DATA_W-1:0] bus_rdata,
  input wire logic baud_tick,
  input wire logic port_dir_out,
  input wire logic rx_in_pin,
  input wire logic tx_io_pin_i,
  output logic tx_io_pin_o,
  output logic tx_io_pin_oe_n,
  output logic comm_done_irq
);
  import huq_pkg::*;

  // bits after the start bit for a frame shape
  function automatic logic [3:0] frame_len(input logic [1:0] fm, input logic npe);
    frame_len = (fm[1] ? LEN_D8 : LEN_D7) + (fm[0] ? LEN_TWO : LEN_ONE);
    if (!npe) begin
      frame_len = frame_len + LEN_ONE;
    end
  endfunction

  // parity bit for a character
  function automatic logic par_bit(input logic [7:0] d, input logic n8, input logic [1:0] pm);
    logic [7:0] v;
    v = n8 ? d : {1'b0, d[6:0]};
    case (pm)
      PM_ZERO: par_bit = 1'b0;
      PM_ONE: par_bit = 1'b1;
      PM_ODD: par_bit = ~^v;
      default: par_bit = ^v;
    endcase
  endfunction

  // bit order swap for msb-first framing
  function automatic logic [7:0] bit_rev(input logic [7:0] d, input logic n8);
    bit_rev = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (n8) begin
        bit_rev[i] = d[DATA_W-1-i];
      end else if (i < DATA_W - 1) begin
        bit_rev[i] = d[DATA_W-2-i];
      end
    end
  endfunction

  logic rxs1_q, rxs2_q, txs1_q, txs2_q;
  huq_state_t state_q, state_d;
  logic [7:0] mode0_q, mode0_d, mode1_q, mode1_d, mode2_q, mode2_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d, rdata_q, rdata_d;
  logic txfull_q, txfull_d, rxfull_q, rxfull_d;
  logic ore_q, ore_d, pek_q, pek_d, fef_q, fef_d, brkf_q, brkf_d;
  logic [3:0] tick_q, tick_d, bit_q, bit_d;
  logic [FRM_W-1:0] shift_q, shift_d, rxb_q, rxb_d;
  logic txo_q, txo_d, oen_q, oen_d, irq_q, irq_d;
  logic in_bit, n8, npe, uart_on, sbos, sbis;
  logic [3:0] flen;
  logic [7:0] tdat, rdat;
  logic [FRM_W-1:0] frame, fmask;

  // pin synchronisers: both pins are asynchronous to core_clk
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxs1_q <= 1'b1;
      rxs2_q <= 1'b1;
      txs1_q <= 1'b1;
      txs2_q <= 1'b1;
    end else begin
      rxs1_q <= rx_in_pin;
      rxs2_q <= rxs1_q;
      txs1_q <= tx_io_pin_i;
      txs2_q <= txs1_q;
    end
  end

  // configuration decode
  assign n8 = mode2_q[M2_FM+1];
  assign npe = mode2_q[M2_NPE];
  assign sbos = mode1_q[M1_SBOS];
  assign sbis = mode1_q[M1_SBIS];
  assign uart_on = mode1_q[M1_CMD];
  assign flen = frame_len(mode2_q[M2_FM +: 2], npe);
  assign in_bit = mode1_q[M1_IOM] ? txs2_q : rxs2_q;
  assign tdat = mode0_q[M0_DIR] ? bit_rev(txbuf_q, n8) : txbuf_q;

  // transmit frame, lsb shifted out first
  always_comb begin
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < DATA_W - 1 || n8) begin
        frame[i+1] = tdat[i];
      end
    end
    if (!npe) begin
      frame[n8 ? LEN_D8 + LEN_ONE : LEN_D7 + LEN_ONE] = par_bit(tdat, n8, mode2_q[M2_PM +: 2]);
    end
    if (mode2_q[M2_BRKE]) begin
      frame = '0;
    end
  end

  // received character and mask of the bits that form the frame
  always_comb begin
    fmask = '0;
    for (int i = 0; i < FRM_W; i++) begin
      fmask[i] = (4'(i) <= flen);
    end
    rdat = n8 ? rxb_q[8:1] : {1'b0, rxb_q[7:1]};
    if (mode0_q[M0_DIR]) begin
      rdat = bit_rev(rdat, n8);
    end
  end

  // next state; error flags never steer the engine
  always_comb begin
    state_d = state_q;
    mode0_d = mode0_q;
    mode1_d = mode1_q;
    mode2_d = mode2_q;
    txbuf_d = txbuf_q;
    rxbuf_d = rxbuf_q;
    txfull_d = txfull_q;
    rxfull_d = rxfull_q;
    ore_d = ore_q;
    pek_d = pek_q;
    fef_d = fef_q;
    brkf_d = brkf_q;
    tick_d = tick_q;
    bit_d = bit_q;
    shift_d = shift_q;
    rxb_d = rxb_q;
    irq_d = 1'b0;
    rdata_d = '0;
    // reading the receive buffer frees it; a completion below wins
    if (bus_req.rd && bus_req.addr == OFS_RXBUF) begin
      rxfull_d = 1'b0;
    end
    case (state_q)
      S_IDLE: begin
        // a pending byte starts a frame when not receiving
        if (txfull_q && sbos && uart_on) begin
          state_d = S_TX;
          shift_d = frame;
          txfull_d = 1'b0;
          tick_d = '0;
          bit_d = '0;
        end else if (!in_bit && sbis && uart_on) begin
          if (baud_tick) begin
            tick_d = tick_q + 4'h1;
            // low beyond half a bit confirms start
            if (tick_q == TICK_HALF) begin
              state_d = S_RX;
              tick_d = '0;
              bit_d = '0;
              rxb_d = '0;
            end
          end
        end else begin
          // a glitch shorter than half a bit is dropped
          tick_d = '0;
        end
      end
      S_TX: begin
        if (baud_tick) begin
          tick_d = tick_q + 4'h1;
          if (tick_q == TICK_LAST) begin
            tick_d = '0;
            bit_d = bit_q + 4'h1;
            shift_d = {1'b1, shift_q[FRM_W-1:1]};
            if (bit_q == flen) begin
              irq_d = 1'b1;
              if (txfull_q && sbos && uart_on) begin
                shift_d = frame;
                txfull_d = 1'b0;
                bit_d = '0;
              end else begin
                state_d = S_IDLE;
              end
            end
          end
        end
      end
      S_RX: begin
        if (baud_tick) begin
          tick_d = tick_q + 4'h1;
          // sample eight ticks after previous sample
          if (tick_q == TICK_LAST) begin
            tick_d = '0;
            bit_d = bit_q + 4'h1;
            rxb_d[bit_q+4'h1] = in_bit;
            if (bit_q + 4'h1 == flen) begin
              state_d = S_IDLE;
              irq_d = 1'b1;
              rxbuf_d = rdat;
              rxfull_d = 1'b1;
              ore_d = rxfull_q;
              pek_d = !npe && (rxb_d[n8 ? LEN_D8 + LEN_ONE : LEN_D7 + LEN_ONE]
                != par_bit(n8 ? rxb_d[8:1] : {1'b0, rxb_q[7:1]}, n8, mode2_q[M2_PM +: 2]));
              // every stop position must be high
              fef_d = !rxb_d[flen] || (mode2_q[M2_FM] && !rxb_d[flen-4'h1]);
              // break when whole frame read zero
              brkf_d = ((rxb_d & fmask) == '0);
            end
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    // both pin enables off resets the function
    if (!sbos && !sbis) begin
      state_d = S_IDLE;
      ore_d = 1'b0;
      rxfull_d = 1'b0;
      tick_d = '0;
    end
    // register writes; a byte written during a load is kept
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_TXBUF: begin
          txbuf_d = bus_req.wdata;
          txfull_d = 1'b1;
        end
        OFS_MODE0: mode0_d = bus_req.wdata;
        OFS_MODE1: mode1_d = bus_req.wdata;
        OFS_MODE2: mode2_d = (bus_req.wdata & MODE2_WMASK) | (mode2_q & ~MODE2_WMASK);
        default: ;
      endcase
    end
    mode2_d[M2_BRKF] = brkf_d;
    // read data, valid the cycle after the strobe
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_RXBUF: rdata_d = rxbuf_q;
        OFS_MODE0: rdata_d = mode0_q;
        OFS_MODE1: rdata_d = mode1_q;
        OFS_MODE2: rdata_d = mode2_q;
        OFS_STAT: begin
          rdata_d[ST_ORE] = ore_q;
          rdata_d[ST_PEK] = pek_q;
          rdata_d[ST_FEF] = fef_q;
          rdata_d[ST_ERE] = ore_q | pek_q | fef_q;
          rdata_d[ST_BUSY] = (state_q != S_IDLE);
          rdata_d[ST_TFULL] = txfull_q;
          rdata_d[ST_RFULL] = rxfull_q;
        end
        default: rdata_d = '0;
      endcase
    end
    // line idles high outside a frame
    txo_d = (state_d == S_TX) ? shift_d[0] : 1'b1;
    // pin driven only as serial output and port set to output
    oen_d = !(sbos && port_dir_out);
  end

  // state registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      mode0_q <= MODE_RST;
      mode1_q <= MODE_RST;
      mode2_q <= MODE_RST;
      txbuf_q <= '0;
      rxbuf_q <= '0;
      rdata_q <= '0;
      txfull_q <= 1'b0;
      rxfull_q <= 1'b0;
      ore_q <= 1'b0;
      pek_q <= 1'b0;
      fef_q <= 1'b0;
      brkf_q <= 1'b0;
      tick_q <= '0;
      bit_q <= '0;
      shift_q <= '1;
      rxb_q <= '0;
      txo_q <= 1'b1;
      oen_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode0_q <= mode0_d;
      mode1_q <= mode1_d;
      mode2_q <= mode2_d;
      txbuf_q <= txbuf_d;
      rxbuf_q <= rxbuf_d;
      rdata_q <= rdata_d;
      txfull_q <= txfull_d;
      rxfull_q <= rxfull_d;
      ore_q <= ore_d;
      pek_q <= pek_d;
      fef_q <= fef_d;
      brkf_q <= brkf_d;
      tick_q <= tick_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      rxb_q <= rxb_d;
      txo_q <= txo_d;
      oen_q <= oen_d;
      irq_q <= irq_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign tx_io_pin_o = txo_q;
  assign tx_io_pin_oe_n = oen_q;
  assign comm_done_irq = irq_q;
endmodule
`default_nettype wire

// [verif/huq_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module huq_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire huq_pkg::huq_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic port_dir_out,
  input wire logic baud_tick,
  input wire logic tx_io_pin_o,
  input wire logic tx_io_pin_oe_n,
  input wire logic comm_done_irq
);
  import huq_pkg::*;
  logic [7:0] m1_q, m1_d;
  logic [3:0] low_q, low_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // mode 1 mirror and ticks spent low, saturating
  always_comb begin
    m1_d = (bus_req.wr && bus_req.addr == OFS_MODE1) ? bus_req.wdata : m1_q;
    low_d = tx_io_pin_o ? 4'h0 : low_q + {3'h0, baud_tick && low_q != 4'hf};
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      m1_q <= 8'h00;
      low_q <= 4'h0;
    end else begin
      m1_q <= m1_d;
      low_q <= low_d;
    end
  end
  chk_oe_follow: assert property (tx_io_pin_oe_n == !($past(m1_q[M1_SBOS]) && $past(port_dir_out)))
    else $error("pin enable disagrees with direction");
  chk_idle_off: assert property ($past(m1_q[5:4]) == 2'h0 && m1_q[5:4] == 2'h0 |=> tx_io_pin_o)
    else $error("line not idle with pins off");
  chk_err_sum: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_STAT
    |-> bus_rdata[ST_ERE] == |bus_rdata[2:0])
    else $error("summary error flag wrong");
  chk_rd_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_rd_unmap: assert property ($past(bus_req.rd) && $past(bus_req.addr) > OFS_STAT |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_irq_pulse: assert property (comm_done_irq |=> !comm_done_irq)
    else $error("completion pulse too long");
  chk_start_len: assert property ($rose(tx_io_pin_o) |-> low_q >= 4'h7)
    else $error("low bit shorter than a bit period");
  chk_busy_tx: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_STAT && !$past(tx_io_pin_o)
    && !tx_io_pin_o |-> bus_rdata[ST_BUSY])
    else $error("busy clear while sending");
endmodule
bind huq_uart huq_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .port_dir_out(port_dir_out), .baud_tick(baud_tick), .tx_io_pin_o(tx_io_pin_o),
  .tx_io_pin_oe_n(tx_io_pin_oe_n), .comm_done_irq(comm_done_irq));
`default_nettype wire

// [verif/huq_remote.sv]
`timescale 1ns/10ps
`default_nettype none
module huq_remote (
  input wire logic core_clk,
  input wire logic baud_tick,
  input wire logic send,
  input wire logic [11:0] frame,
  input wire logic [3:0] nbits,
  input wire logic line_in,
  output var logic line_out,
  output var logic [11:0] got
);
  logic [11:0] sh;
  logic [3:0] sn, rn;
  logic [2:0] st, rt;
  logic tb = 1'b0, rb = 1'b0, prv = 1'b1;
  initial line_out = 1'b1;
  // sender: bit 0 first, eight ticks a bit, idle high
  always @(posedge core_clk) begin
    if (send) begin
      {sh, sn, st, tb, line_out} <= {frame, nbits, 3'h0, 1'b1, frame[0]};
    end else if (tb && baud_tick) begin
      st <= st + 3'h1;
      if (st == 3'h7) begin
        sh <= {1'b1, sh[11:1]};
        sn <= sn - 4'h1;
        line_out <= (sn == 4'h1) | sh[1];
        tb <= sn != 4'h1;
      end
    end
  end
  // receiver: a falling edge starts, each bit sampled four ticks in
  always @(posedge core_clk) begin
    prv <= line_in;
    if (!rb && prv === 1'b1 && line_in === 1'b0) begin
      {rb, rt, rn} <= {1'b1, 3'h0, 4'h0};
    end else if (rb && baud_tick) begin
      rt <= rt + 3'h1;
      if (rt == 3'h3) begin
        got <= {line_in, got[11:1]};
        rn <= rn + 4'h1;
        rb <= rn != nbits - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/half_duplex_uart_serial1_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module half_duplex_uart_serial1_tb_top;
  import huq_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, baud_tick = 1'b0, port_dir_out = 1'b1;
  logic single = 1'b0, glitch = 1'b0, send = 1'b0;
  logic o, oe_n, irq, pl, wv;
  huq_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic [11:0] frame = '0, got;
  logic [3:0] nbits = 4'h1;
  logic [1:0] tc = 2'h0;
  int fails = 0, checked = 0;
  localparam logic [15:0] ROWS [8] = '{16'h22a5, 16'h123c, 16'h027e, 16'h3081, 16'h2400, 16'h2813, 16'h2c13,
    16'h31ff};
  assign wv = oe_n ? pl : o;
  huq_uart dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .baud_tick(baud_tick), .port_dir_out(port_dir_out), .rx_in_pin(single | (pl & ~glitch)),
    .tx_io_pin_i(wv), .tx_io_pin_o(o), .tx_io_pin_oe_n(oe_n), .comm_done_irq(irq));
  huq_remote rem_u (.core_clk(core_clk), .baud_tick(baud_tick), .send(send), .frame(frame),
    .nbits(nbits), .line_in(wv), .line_out(pl), .got(got));
  initial forever #5 core_clk = ~core_clk;
  // baud source: a tick every fourth clock keeps frames short
  always @(posedge core_clk) begin
    tc <= tc + 2'h1;
    baud_tick <= tc == 2'h3;
  end
  // expected frame from mode 2 and a byte: count above, bits below
  function automatic logic [15:0] mk(input logic [7:0] m, input logic [7:0] d);
    logic [11:0] f;
    int n;
    n = m[5] ? 8 : 7;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i + 1] = d[i];
    if (!m[1]) begin
      f[n + 1] = m[3] ? (^(d & (m[5] ? 8'hff : 8'h7f)) ^ !m[2]) : m[2];
      n++;
    end
    n = n + 1 + (m[4] ? 2 : 1);
    if (m[0]) f = '0;
    return {4'(n), f};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk(bus_rdata, e);
  endtask
  // remote sends a frame of the given count
  task automatic pt(input logic [15:0] nf);
    @(posedge core_clk);
    {nbits, frame} <= nf;
    send <= 1'b1;
    @(posedge core_clk);
    send <= 1'b0;
  endtask
  task automatic wirq(input int lim, input logic want);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
    if ((n < lim) !== want) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [15:0] e;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    // bit order lsb first, then both pin enables on
    wr(OFS_MODE0, 8'h00);
    wr(OFS_MODE1, 8'h39);
    for (int i = 0; i < 8; i++) begin
      e = mk(ROWS[i][15:8], ROWS[i][7:0]);
      wr(OFS_MODE2, ROWS[i][15:8]);
      nbits <= e[15:12];
      wr(OFS_TXBUF, ROWS[i][7:0]);
      wirq(2000, 1'b1);
      chk(got >> (5'd12 - e[15:12]), e[11:0] & ~(12'hfff << e[15:12]));
      if (!ROWS[i][8]) begin
        pt(e);
        wirq(2000, 1'b1);
        rc(OFS_RXBUF, ROWS[i][7:0] & (ROWS[i][13] ? 8'hff : 8'h7f));
        rc(OFS_STAT, 8'h00);
      end
      $display("row %0d done", i);
    end
    wr(OFS_MODE2, 8'h28);
    e = mk(8'h28, 8'h13);
    pt(e ^ 16'h0200);
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h4a);
    pt(e);
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h49);
    rc(OFS_RXBUF, 8'h13);
    pt(e);
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h40);
    rc(OFS_RXBUF, 8'h13);
    wr(OFS_MODE2, 8'h22);
    pt(16'ha000);
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h4c);
    rc(OFS_MODE2, 8'ha2);
    pt(mk(8'h22, 8'ha5));
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h49);
    $display("error test done");
    wr(OFS_MODE1, 8'h09);
    rc(OFS_STAT, 8'h00);
    wr(OFS_MODE1, 8'h39);
    @(posedge core_clk);
    glitch <= 1'b1;
    repeat (12) @(posedge core_clk);
    glitch <= 1'b0;
    wirq(600, 1'b0);
    rc(OFS_STAT, 8'h00);
    wr(OFS_MODE2, 8'h31);
    wr(OFS_TXBUF, 8'h00);
    pt(mk(8'h02, 8'h7e));
    rc(OFS_STAT, 8'h10);
    wirq(2000, 1'b1);
    rc(OFS_STAT, 8'h00);
    wr(OFS_MODE2, 8'h22);
    // byte queued mid-frame follows with no idle time
    e = mk(8'h22, 8'h96);
    nbits <= e[15:12];
    wr(OFS_TXBUF, 8'h3c);
    wr(OFS_TXBUF, 8'h96);
    wirq(2000, 1'b1);
    chk(o, 1'b0);
    @(posedge core_clk);
    #1;
    wirq(2000, 1'b1);
    chk(got >> (5'd12 - e[15:12]), e[11:0] & ~(12'hfff << e[15:12]));
    $display("chain test done");
    wr(OFS_MODE1, 8'hb9);
    // software turns the shared pin to input
    port_dir_out <= 1'b0;
    single <= 1'b1;
    pt(mk(8'h22, 8'h5a));
    wirq(2000, 1'b1);
    rc(OFS_RXBUF, 8'h5a);
    rc(3'h6, 8'h00);
    $display("pin test done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rc(OFS_MODE2, 8'h00);
    rc(OFS_MODE1, 8'h00);
    chk({o, oe_n, irq}, 3'h6);
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
